// File: rtl/bvcm_monitor.sv
// bus voltage and current monitor with serial register access
`timescale 1ns/1ns
// What this block does
// (RL1) sample bus voltage and current continuously, 10-bit and 7-bit results
// (RL2) converter sampling stays off after reset until software enables it
// (RL3) writing zero to power control bit 6 starts sampling
// (RL4) writing one to power control bit 6 stops sampling
// (RL5) each voltage sample updates low and high result registers, both readable; the high register here reloads only when the low byte is read
// (RL6) reading the low byte captures the high byte for a coherent later read
// (RL7) the master reads voltage as two bytes starting at the low register
// (RL8) each current sample updates the current result register
// (RL9) voltage is high bits 1:0 above low bits 7:0
// (RL10) one voltage step is 25 mV
// (RL11) one current step is 50 mA, current register top bit reads zero
// (RL12) voltage and current convert alternately, about 1 ms apart
// (RL13) no alert for new results; the master polls
// (RL14) each voltage result is compared against programmed alarm thresholds
// (RL15) voltage alarms run when the alarm-off bit is zero
// (RL16) voltage alarms run only while sampling is enabled
// (RL17) safe-zero threshold fixed at 0.75 V falling, 50 mV hysteresis
// (RL18) safe-zero status is one at or below threshold, zero above threshold plus hysteresis (0.8 V)
// (RL19) safe-zero status is read-only and follows the comparator unlatched
// (RL20) a safe-zero change with its mask set raises the extended alert bit
// (RL21) safe-zero status is valid only while bus detect is active
// (RL22) command 0x33 enables monitoring and sets bus detect active
// (RL23) command 0x22 disables bus and safe-zero monitoring
// (RL24) unused high voltage register bits 7:2 read zero
module bvcm_monitor #(
  parameter logic [6:0]  I2C_ADDR     = bvcm_pkg::I2C_ADDR_DEFAULT,
  parameter int unsigned CONV_SPACING = bvcm_pkg::CONV_SPACING_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       afeDone,
  input  wire logic [9:0] afeData,
  output logic            afeStart,
  output logic            afeSelCurrent,
  output logic            alertN
);
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR_ST, I2C_ADDR_ACK, I2C_PTR, I2C_PTR_ACK,
    I2C_WRITE, I2C_WRITE_ACK, I2C_READ, I2C_READ_ACK
  } bvcm_i2c_state_t;

  bvcm_i2c_state_t state;
  logic            sclQ;
  logic            sdaQ;
  logic            sclPrev;
  logic            sdaPrev;
  logic            sclRise;
  logic            sclFall;
  logic            startCond;
  logic            stopCond;
  logic [3:0]      bitCnt;
  logic            byteDone;
  logic [7:0]      shiftIn;
  logic [7:0]      txByte;
  logic [7:0]      regPtr;
  logic            isRead;
  logic            masterNack;
  logic            wrStrobe;
  logic            txLoad;
  logic [7:0]      rdData;
  logic [7:0]      powerControl;
  logic [7:0]      alertMask;
  logic [7:0]      extMask;
  logic [7:0]      alert;
  logic [7:0]      alertSet;
  logic [7:0]      alertClr;
  logic [9:0]      almHi;
  logic [9:0]      almLo;
  logic [1:0]      voltHighHeld;
  logic            busDetectActive;
  logic            safeZero;
  logic            safePrev;
  logic            alarmsLive;
  logic [9:0]      voltResult;
  logic [6:0]      currResult;
  logic            voltStrobe;
  logic            currStrobe;

  // converter sequencing; runs while the sampling-off bit is clear
  bvcm_conv_seq #(
    .SPACING (CONV_SPACING)
  ) u_seq (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .enable        (!powerControl[bvcm_pkg::SAMPLING_OFF_BIT]), // RL3 RL4
    .afeDone       (afeDone),
    .afeData       (afeData),
    .afeStart      (afeStart),
    .afeSelCurrent (afeSelCurrent),
    .voltResult    (voltResult),
    .currResult    (currResult),
    .voltStrobe    (voltStrobe),
    .currStrobe    (currStrobe)
  );

  // pin sampling and previous values for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sclQ    <= 1'b1;
      sdaQ    <= 1'b1;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclQ    <= scl;
      sdaQ    <= sdaIn;
      sclPrev <= sclQ;
      sdaPrev <= sdaQ;
    end
  end

  // bus events
  assign sclRise   = sclQ & ~sclPrev;
  assign sclFall   = ~sclQ & sclPrev;
  assign startCond = sclQ & sclPrev & sdaPrev & ~sdaQ;
  assign stopCond  = sclQ & sclPrev & ~sdaPrev & sdaQ;
  assign byteDone  = bitCnt == 4'd8;
  assign wrStrobe  = sclFall && state == I2C_WRITE && byteDone;
  assign txLoad    = sclFall && ((state == I2C_ADDR_ACK && isRead) ||
                                 (state == I2C_READ_ACK && !masterNack));

  // serial slave state machine
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state      <= I2C_IDLE;
      bitCnt     <= 4'h0;
      shiftIn    <= 8'h00;
      isRead     <= 1'b0;
      masterNack <= 1'b0;
    end
    else if (startCond)
    begin
      state  <= I2C_ADDR_ST;
      bitCnt <= 4'h0;
    end
    else if (stopCond)
      state <= I2C_IDLE;
    else if (sclRise)
    begin
      if (state == I2C_ADDR_ST || state == I2C_PTR || state == I2C_WRITE)
      begin
        shiftIn <= {shiftIn[6:0], sdaQ};
        bitCnt  <= bitCnt + 4'h1;
      end
      if (state == I2C_READ)
        bitCnt <= bitCnt + 4'h1;
      if (state == I2C_READ_ACK)
        masterNack <= sdaQ;
    end
    else if (sclFall)
    begin
      unique case (state)
        I2C_ADDR_ST:
        begin
          if (byteDone)
          begin
            bitCnt <= 4'h0;
            isRead <= shiftIn[0];
            state  <= (shiftIn[7:1] == I2C_ADDR) ? I2C_ADDR_ACK : I2C_IDLE;
          end
        end
        I2C_PTR:
        begin
          if (byteDone)
          begin
            bitCnt <= 4'h0;
            state  <= I2C_PTR_ACK;
          end
        end
        I2C_WRITE:
        begin
          if (byteDone)
          begin
            bitCnt <= 4'h0;
            state  <= I2C_WRITE_ACK;
          end
        end
        I2C_READ:
        begin
          if (byteDone)
          begin
            bitCnt <= 4'h0;
            state  <= I2C_READ_ACK;
          end
        end
        I2C_ADDR_ACK:  state <= isRead ? I2C_READ : I2C_PTR;
        I2C_PTR_ACK:   state <= I2C_WRITE;
        I2C_WRITE_ACK: state <= I2C_WRITE;
        I2C_READ_ACK:  state <= masterNack ? I2C_IDLE : I2C_READ;
        default:       state <= I2C_IDLE;
      endcase
    end
  end

  // open-drain data: enable pulls low for ack and zero bits
  always_ff @(posedge clk_sys)
  begin
    sdaOut <= 1'b0;
    if (!reset_n || startCond || stopCond)
      sdaOe <= 1'b0;
    else if (sclFall)
    begin
      unique case (state)
        I2C_ADDR_ST:  sdaOe <= byteDone && shiftIn[7:1] == I2C_ADDR;
        I2C_PTR:      sdaOe <= byteDone;
        I2C_WRITE:    sdaOe <= byteDone;
        I2C_ADDR_ACK: sdaOe <= isRead && !rdData[7];
        I2C_READ:     sdaOe <= !byteDone && !txByte[3'(4'd7 - bitCnt)];
        I2C_READ_ACK: sdaOe <= !masterNack && !rdData[7];
        default:      sdaOe <= 1'b0;
      endcase
    end
  end

  // register pointer, transmit byte, auto-increment after each byte
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      regPtr <= 8'h00;
      txByte <= 8'h00;
    end
    else if (sclFall && state == I2C_PTR && byteDone)
      regPtr <= shiftIn;
    else if (wrStrobe)
      regPtr <= regPtr + 8'h01;
    else if (txLoad)
    begin
      txByte <= rdData;
      regPtr <= regPtr + 8'h01; // RL7
    end
  end

  // high byte captured when the low byte is sent
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      voltHighHeld <= 2'h0;
    else if (txLoad && regPtr == bvcm_pkg::VOLT_LOW_OFF)
      voltHighHeld <= voltResult[9:8]; // RL6
  end

  // register read mux
  always_comb
  begin
    unique case (regPtr)
      bvcm_pkg::PWR_CTRL_OFF:    rdData = powerControl;
      bvcm_pkg::PWR_STAT_OFF:    rdData = {7'h00, busDetectActive} << bvcm_pkg::BUS_DETECT_BIT;
      bvcm_pkg::EXT_STAT_OFF:    rdData = {7'h00, safeZero} << bvcm_pkg::SAFE_ZERO_BIT; // RL19
      bvcm_pkg::ALERT_OFF:       rdData = alert;
      bvcm_pkg::ALERT_MASK_OFF:  rdData = alertMask;
      bvcm_pkg::EXT_MASK_OFF:    rdData = extMask;
      bvcm_pkg::VOLT_LOW_OFF:    rdData = voltResult[7:0]; // RL5 RL9
      bvcm_pkg::VOLT_HIGH_OFF:   rdData = {6'h00, voltHighHeld}; // RL24
      bvcm_pkg::CURR_OFF:        rdData = {1'b0, currResult}; // RL11
      bvcm_pkg::ALM_HI_LOW_OFF:  rdData = almHi[7:0];
      bvcm_pkg::ALM_HI_HIGH_OFF: rdData = {6'h00, almHi[9:8]};
      bvcm_pkg::ALM_LO_LOW_OFF:  rdData = almLo[7:0];
      bvcm_pkg::ALM_LO_HIGH_OFF: rdData = {6'h00, almLo[9:8]};
      default:                   rdData = 8'h00;
    endcase
  end

  // writable control registers
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      powerControl <= bvcm_pkg::PWR_CTRL_RESET; // RL2
      alertMask    <= bvcm_pkg::ALERT_MASK_RESET;
      extMask      <= bvcm_pkg::EXT_MASK_RESET;
      almHi        <= bvcm_pkg::ALM_HI_RESET;
      almLo        <= bvcm_pkg::ALM_LO_RESET;
    end
    else if (wrStrobe)
    begin
      unique case (regPtr)
        bvcm_pkg::PWR_CTRL_OFF:    powerControl <= shiftIn & bvcm_pkg::PWR_CTRL_RW_MASK;
        bvcm_pkg::ALERT_MASK_OFF:  alertMask <= shiftIn;
        bvcm_pkg::EXT_MASK_OFF:    extMask <= shiftIn;
        bvcm_pkg::ALM_HI_LOW_OFF:  almHi[7:0] <= shiftIn;
        bvcm_pkg::ALM_HI_HIGH_OFF: almHi[9:8] <= shiftIn[1:0];
        bvcm_pkg::ALM_LO_LOW_OFF:  almLo[7:0] <= shiftIn;
        bvcm_pkg::ALM_LO_HIGH_OFF: almLo[9:8] <= shiftIn[1:0];
        default:                   almLo <= almLo;
      endcase
    end
  end

  // monitoring commands
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      busDetectActive <= 1'b0;
    else if (wrStrobe && regPtr == bvcm_pkg::COMMAND_OFF)
    begin
      if (shiftIn == bvcm_pkg::CMD_ENABLE_DETECT)
        busDetectActive <= 1'b1; // RL22
      else if (shiftIn == bvcm_pkg::CMD_DISABLE_DETECT)
        busDetectActive <= 1'b0; // RL23
    end
  end

  // safe-zero comparator with hysteresis on each voltage result
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || !busDetectActive)
      safeZero <= 1'b0; // RL21
    else if (voltStrobe)
    begin
      if (voltResult <= bvcm_pkg::SAFE0_SET_CODE)
        safeZero <= 1'b1; // RL10 RL17 RL18
      else if (voltResult > bvcm_pkg::SAFE0_CLR_CODE)
        safeZero <= 1'b0; // RL17 RL18
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      safePrev <= 1'b0;
    else
      safePrev <= safeZero;
  end

  // alarm gating and sticky alert events
  assign alarmsLive = !powerControl[bvcm_pkg::SAMPLING_OFF_BIT] && // RL16
                      !powerControl[bvcm_pkg::ALARM_OFF_BIT]; // RL15

  always_comb
  begin
    alertSet = 8'h00;
    alertSet[bvcm_pkg::ALERT_HI_BIT] = voltStrobe && alarmsLive && voltResult > almHi; // RL14
    alertSet[bvcm_pkg::ALERT_LO_BIT] = voltStrobe && alarmsLive && voltResult < almLo; // RL14
    alertSet[bvcm_pkg::ALERT_EXT_BIT] = busDetectActive && (safeZero != safePrev) &&
                                        extMask[bvcm_pkg::SAFE_ZERO_BIT]; // RL20
    alertClr = (wrStrobe && regPtr == bvcm_pkg::ALERT_OFF) ? shiftIn : 8'h00;
  end

  // write one to clear; a same-cycle event wins
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      alert <= 8'h00;
    else
      alert <= (alert & ~alertClr) | alertSet;
  end

  // alert pin from unmasked flags only, never from result ready
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      alertN <= 1'b1;
    else
      alertN <= ~|(alert & alertMask); // RL13
  end

  a_sampling_reset: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> powerControl[bvcm_pkg::SAMPLING_OFF_BIT])
    else $error("sampling enabled out of reset"); // RL2
  a_sampling_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wrStrobe && regPtr == bvcm_pkg::PWR_CTRL_OFF && !shiftIn[bvcm_pkg::SAMPLING_OFF_BIT]
    |=> !powerControl[bvcm_pkg::SAMPLING_OFF_BIT])
    else $error("zero write did not enable sampling"); // RL3
  a_high_coherent: assert property (@(posedge clk_sys) disable iff (!reset_n)
    txLoad && regPtr == bvcm_pkg::VOLT_LOW_OFF |=> voltHighHeld == $past(voltResult[9:8]))
    else $error("high byte not captured on low read"); // RL6
  a_current_top_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    txLoad && regPtr == bvcm_pkg::CURR_OFF |=> !txByte[7] && txByte[6:0] == $past(currResult))
    else $error("current byte wrong"); // RL11
  a_alarm_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(alert[bvcm_pkg::ALERT_HI_BIT]) || $rose(alert[bvcm_pkg::ALERT_LO_BIT])
    |-> $past(alarmsLive) && $past(voltStrobe, 1))
    else $error("alarm raised while gated"); // RL15 RL16
  a_alarm_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    voltStrobe && alarmsLive && voltResult > almHi |=> alert[bvcm_pkg::ALERT_HI_BIT])
    else $error("high alarm missed"); // RL14
  a_safe_zero_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    busDetectActive && voltStrobe && voltResult <= bvcm_pkg::SAFE0_SET_CODE
    ##1 busDetectActive |-> safeZero)
    else $error("safe-zero status not set"); // RL18
  a_safe_zero_valid: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !busDetectActive |=> !safeZero) else $error("safe-zero without detect"); // RL21
  a_ext_alert: assert property (@(posedge clk_sys) disable iff (!reset_n)
    busDetectActive && safeZero != safePrev && extMask[bvcm_pkg::SAFE_ZERO_BIT]
    |=> alert[bvcm_pkg::ALERT_EXT_BIT])
    else $error("extended alert not raised"); // RL20
  a_cmd_detect: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wrStrobe && regPtr == bvcm_pkg::COMMAND_OFF && shiftIn == bvcm_pkg::CMD_ENABLE_DETECT
    |=> busDetectActive)
    else $error("enable command ignored"); // RL22
  a_cmd_undetect: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wrStrobe && regPtr == bvcm_pkg::COMMAND_OFF && shiftIn == bvcm_pkg::CMD_DISABLE_DETECT
    |=> !busDetectActive) else $error("disable command ignored"); // RL23
  a_no_result_alert: assert property (@(posedge clk_sys) disable iff (!reset_n)
    currStrobe && !busDetectActive |=> alert == $past(alert & ~alertClr))
    else $error("result raised an alert flag"); // RL13
endmodule

// File: shared/bvcm_pkg.sv
// constants shared by the bus voltage and current monitor
package bvcm_pkg;
  // register offsets
  localparam logic [7:0] ALERT_OFF       = 8'h10;
  localparam logic [7:0] ALERT_MASK_OFF  = 8'h12;
  localparam logic [7:0] EXT_MASK_OFF    = 8'h18;
  localparam logic [7:0] PWR_CTRL_OFF    = 8'h1c;
  localparam logic [7:0] PWR_STAT_OFF    = 8'h1e;
  localparam logic [7:0] EXT_STAT_OFF    = 8'h20;
  localparam logic [7:0] COMMAND_OFF     = 8'h23;
  localparam logic [7:0] VOLT_LOW_OFF    = 8'h70;
  localparam logic [7:0] VOLT_HIGH_OFF   = 8'h71;
  localparam logic [7:0] CURR_OFF        = 8'h72;
  localparam logic [7:0] ALM_HI_LOW_OFF  = 8'h76;
  localparam logic [7:0] ALM_HI_HIGH_OFF = 8'h77;
  localparam logic [7:0] ALM_LO_LOW_OFF  = 8'h78;
  localparam logic [7:0] ALM_LO_HIGH_OFF = 8'h79;
  // reset values and the power control write mask
  localparam logic [7:0] PWR_CTRL_RESET   = 8'h60;
  localparam logic [7:0] PWR_CTRL_RW_MASK = 8'h77;
  localparam logic [7:0] ALERT_MASK_RESET = 8'h07;
  localparam logic [7:0] EXT_MASK_RESET   = 8'h01;
  localparam logic [9:0] ALM_HI_RESET     = 10'h3ff;
  localparam logic [9:0] ALM_LO_RESET     = 10'h000;
  // field positions
  localparam int SAMPLING_OFF_BIT  = 6;
  localparam int ALARM_OFF_BIT     = 5;
  localparam int BUS_DETECT_BIT    = 3;
  localparam int SAFE_ZERO_BIT     = 0;
  localparam int ALERT_HI_BIT      = 0;
  localparam int ALERT_LO_BIT      = 1;
  localparam int ALERT_EXT_BIT     = 2;
  // command codes
  localparam logic [7:0] CMD_ENABLE_DETECT  = 8'h33;
  localparam logic [7:0] CMD_DISABLE_DETECT = 8'h22;
  // result scaling and the fixed safe-zero threshold
  localparam int VOLT_LSB_MV   = 25;
  localparam int CURR_LSB_MA   = 50;
  localparam int SAFE0_MV      = 750;
  localparam int SAFE0_HYST_MV = 50;
  localparam logic [9:0] SAFE0_SET_CODE = 10'(SAFE0_MV / VOLT_LSB_MV);
  localparam logic [9:0] SAFE0_CLR_CODE = 10'((SAFE0_MV + SAFE0_HYST_MV) / VOLT_LSB_MV);
  // timing
  localparam int CLK_MHZ             = 50;
  localparam int CONV_SPACING_US     = 1000;
  localparam int CONV_SPACING_CYCLES = CONV_SPACING_US * CLK_MHZ;
  // serial address, value arbitrary
  localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h2a;
endpackage

// File: rtl/bvcm_conv_seq.sv
// converter sequencer alternating voltage and current conversions
`timescale 1ns/1ns
module bvcm_conv_seq #(
  parameter int unsigned SPACING = bvcm_pkg::CONV_SPACING_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       enable,
  input  wire logic       afeDone,
  input  wire logic [9:0] afeData,
  output logic            afeStart,
  output logic            afeSelCurrent,
  output logic [9:0]      voltResult,
  output logic [6:0]      currResult,
  output logic            voltStrobe,
  output logic            currStrobe
);
  typedef enum logic {SEQ_WAIT, SEQ_BUSY} bvcm_seq_state_t;

  bvcm_seq_state_t seqState;
  logic [16:0]     waitCnt;

  // spacing timer, start pulse and channel toggle
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || !enable)
    begin
      seqState      <= SEQ_WAIT;
      waitCnt       <= 17'h00000;
      afeStart      <= 1'b0;
      afeSelCurrent <= 1'b0;
    end
    else
    begin
      afeStart <= 1'b0;
      unique case (seqState)
        SEQ_WAIT:
        begin
          if (waitCnt == 17'(SPACING - 1))
          begin
            waitCnt  <= 17'h00000;
            afeStart <= 1'b1; // RL1
            seqState <= SEQ_BUSY;
          end
          else
            waitCnt <= waitCnt + 17'h00001;
        end
        SEQ_BUSY:
        begin
          if (afeDone)
          begin
            afeSelCurrent <= ~afeSelCurrent; // RL12
            seqState      <= SEQ_WAIT;
          end
        end
      endcase
    end
  end

  // result capture, kept while stopped
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      voltResult <= 10'h000;
      currResult <= 7'h00;
      voltStrobe <= 1'b0;
      currStrobe <= 1'b0;
    end
    else
    begin
      voltStrobe <= enable && seqState == SEQ_BUSY && afeDone && !afeSelCurrent;
      currStrobe <= enable && seqState == SEQ_BUSY && afeDone && afeSelCurrent;
      if (enable && seqState == SEQ_BUSY && afeDone && !afeSelCurrent)
        voltResult <= afeData; // RL5
      if (enable && seqState == SEQ_BUSY && afeDone && afeSelCurrent)
        currResult <= afeData[6:0]; // RL8
    end
  end

  a_idle_when_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !enable |=> !afeStart) else $error("conversion started while stopped"); // RL4
  a_channel_swap: assert property (@(posedge clk_sys) disable iff (!reset_n)
    voltStrobe |-> afeSelCurrent) else $error("voltage not followed by current"); // RL12
endmodule

// File: rtl/none_placeholder_removed.sv
// intentionally empty
`timescale 1ns/1ns

// File: testbench/bvcm_tcpm_model.sv
// serial bus master model standing in for the port manager
`timescale 1ns/1ns
module bvcm_tcpm_model #(
  parameter logic [6:0] ADDR = bvcm_pkg::I2C_ADDR_DEFAULT
) (
  input  wire logic       clk_sys,
  input  wire logic       sda,
  output logic            scl,
  output logic            sdaOe,
  output logic [7:0]      rdByte,
  output logic            rdValid,
  output int              nackCount
);
  initial
  begin
    scl = 1'b1;
    sdaOe = 1'b0;
    rdByte = 8'h00;
    rdValid = 1'b0;
    nackCount = 0;
  end
  // one phase of the serial clock, ten core cycles long
  task automatic ph(input logic oe, input logic c);
    sdaOe = oe;
    scl = c;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask
  // data set while clock low, sampled at end of high phase
  task automatic bitx(input logic b, output logic r);
    ph(~b, 1'b0);
    ph(~b, 1'b1);
    r = sda;
  endtask
  // start or repeated start
  task automatic go();
    ph(1'b0, 1'b0);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
  endtask
  task automatic sendb(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    if (r !== 1'b0) nackCount++;
  endtask
  // n = 0 writes d at a, else polls n bytes from a, last one unacknowledged
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int n);
    logic [7:0] b;
    logic       r;
    go();
    sendb({ADDR, 1'b0});
    sendb(a);
    if (n == 0) sendb(d);
    else
    begin
      go();
      sendb({ADDR, 1'b1});
      for (int k = 0; k < n; k++)
      begin
        for (int i = 7; i >= 0; i--)
        begin
          bitx(1'b1, r);
          b[i] = r;
        end
        bitx(k == n - 1, r);
        rdByte = b;
        rdValid = 1'b1;
        @(posedge clk_sys);
        #1;
        rdValid = 1'b0;
      end
    end
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the bus voltage and current monitor
`timescale 1ns/1ns
module tb_top;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        afeDone = 1'b0;
  logic [9:0]  afeData = 10'h000;
  logic        scl;
  logic        masterOe;
  logic        sdaOe;
  logic        sdaOut;
  logic        afeStart;
  logic        afeSelCurrent;
  logic        alertN;
  logic [7:0]  rdByte;
  logic        rdValid;
  int          nackCount;
  logic        hold = 1'b0;
  logic        pend = 1'b0;
  logic        pendCur = 1'b0;
  logic        lastCur = 1'b1;
  logic [9:0]  vNext = 10'h2a5;
  logic [6:0]  lastI = 7'h00;
  logic [15:0] lfsr = 16'h004a;
  logic [15:0] expQ[$];
  logic [11:0] szTab[4] = '{12'hc14, 12'h41f, 12'h821, 12'h01f};
  int          starts = 0;
  int          vDone = 0;
  int          errors = 0;
  int          tests_run = 0;
  int          k;
  int          k0;
  // open-drain data wire with pull-up
  wire         sdaLine = ~masterOe & (sdaOe ? sdaOut : 1'b1);

  bvcm_monitor #(.CONV_SPACING(20)) i_bvcm_monitor (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .scl           (scl),
    .sdaIn         (sdaLine),
    .sdaOut        (sdaOut),
    .sdaOe         (sdaOe),
    .afeDone       (afeDone),
    .afeData       (afeData),
    .afeStart      (afeStart),
    .afeSelCurrent (afeSelCurrent),
    .alertN        (alertN)
  );
  bvcm_tcpm_model i_bvcm_tcpm_model (
    .clk_sys   (clk_sys),
    .sda       (sdaLine),
    .scl       (scl),
    .sdaOe     (masterOe),
    .rdByte    (rdByte),
    .rdValid   (rdValid),
    .nackCount (nackCount)
  );

  always #10 clk_sys = ~clk_sys;

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // note a masked expectation, then poll one byte
  task automatic rdq(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    expQ.push_back({m, e});
    i_bvcm_tcpm_model.xfer(a, 8'h00, 1);
  endtask
  // let one voltage conversion of value v land, then freeze the front end
  task automatic newv(input logic [9:0] v);
    int n0;
    @(posedge clk_sys);
    vNext = v;
    n0 = vDone;
    hold = 1'b0;
    for (k = 0; k < 400 && vDone == n0; k++) @(posedge clk_sys);
    hold = 1'b1;
    for (k = 0; k < 400 && !pend; k++) @(posedge clk_sys);
    #1;
    check(8'(k < 400), 8'h01, "conversion wait");
  endtask

  // front end: one answer per start, withheld while hold is set
  always @(posedge clk_sys)
  begin
    #1;
    afeDone = 1'b0;
    if (afeStart === 1'b1)
    begin
      check({7'h00, afeSelCurrent}, {7'h00, ~lastCur}, "channel order");
      lastCur = afeSelCurrent;
      pendCur = afeSelCurrent;
      pend = 1'b1;
      starts++;
    end
    else if (pend && !hold)
    begin
      lfsr = lfsr_next(lfsr);
      if (pendCur) lastI = lfsr[6:0];
      afeData = pendCur ? lfsr[9:0] : vNext;
      afeDone = 1'b1;
      pend = 1'b0;
      vDone += int'(!pendCur);
    end
  end

  // compare each polled byte with the oldest note
  always @(posedge clk_sys)
  begin
    logic [15:0] e;
    if (rdValid === 1'b1)
    begin
      if (expQ.size() == 0) check(8'h01, 8'h00, "unexpected byte");
      else
      begin
        e = expQ.pop_front();
        check(rdByte & e[15:8], e[7:0], "read byte");
      end
    end
  end

  initial
  begin
    #2_000_000;
    errors++;
    wrap_up();
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rdq(8'h1c, 8'hff, 8'h60);
    rdq(8'h71, 8'hff, 8'h00);
    check(8'(starts), 8'h00, "starts while off");
    $display("test reset done");
    i_bvcm_tcpm_model.xfer(8'h1c, 8'h20, 0);
    newv(10'h2a5);
    expQ.push_back(16'hffa5);
    expQ.push_back(16'hff02);
    expQ.push_back({8'hff, 1'b0, lastI});
    i_bvcm_tcpm_model.xfer(8'h70, 8'h00, 3);
    check({7'h00, alertN}, 8'h01, "alertN on results");
    rdq(8'h70, 8'hff, 8'ha5);
    newv(10'h1ff);
    rdq(8'h71, 8'hff, 8'h02);
    $display("test results done");
    i_bvcm_tcpm_model.xfer(8'h77, 8'h01, 0);
    i_bvcm_tcpm_model.xfer(8'h76, 8'h00, 0);
    newv(10'h1ff);
    rdq(8'h10, 8'h01, 8'h00);
    i_bvcm_tcpm_model.xfer(8'h1c, 8'h00, 0);
    newv(10'h100);
    rdq(8'h10, 8'h01, 8'h00);
    newv(10'h101);
    rdq(8'h10, 8'h01, 8'h01);
    check({7'h00, alertN}, 8'h00, "alertN alarm");
    $display("test alarms done");
    i_bvcm_tcpm_model.xfer(8'h1c, 8'h40, 0);
    lastCur = 1'b1;
    hold = 1'b0;
    k0 = starts;
    i_bvcm_tcpm_model.xfer(8'h10, 8'h07, 0);
    check(8'(starts - k0), 8'h00, "starts after stop");
    rdq(8'h10, 8'h01, 8'h00);
    check({7'h00, alertN}, 8'h01, "alertN stopped");
    $display("test stop done");
    i_bvcm_tcpm_model.xfer(8'h23, 8'h33, 0);
    rdq(8'h1e, 8'h08, 8'h08);
    i_bvcm_tcpm_model.xfer(8'h1c, 8'h20, 0);
    foreach (szTab[i])
    begin
      newv(szTab[i][9:0]);
      i_bvcm_tcpm_model.xfer(8'h20, 8'h00, 0);
      rdq(8'h20, 8'h01, {7'h00, szTab[i][10]});
      rdq(8'h10, 8'h04, {5'h00, szTab[i][11], 2'h0});
      i_bvcm_tcpm_model.xfer(8'h10, 8'h07, 0);
    end
    i_bvcm_tcpm_model.xfer(8'h23, 8'h22, 0);
    rdq(8'h1e, 8'h08, 8'h00);
    check(8'(nackCount), 8'h00, "missing acks");
    $display("test safe zero done");
    wrap_up();
  end
endmodule
